// *** include/psm_params.svh ***
// psm_params.svh: offsets, field positions, reset values and codes of the pin select matrix.
// assumes an 8-bit register address space reached over a plain strobe port.
`ifndef PSM_PARAMS_SVH
`define PSM_PARAMS_SVH

// ****************************************
// register map
// ****************************************
`define PSM_LOCK_ADDR 8'h00
`define PSM_IN_BASE 8'h01
`define PSM_OUT_BASE 8'h20
`define PSM_NUM_IN 28
`define PSM_NUM_OUT 16

// ****************************************
// fields and reset values
// ****************************************
`define PSM_SEL_W 5
`define PSM_LOCK_BIT 0
`define PSM_OUT_RST 5'h00
`define PSM_IN_RST {28{5'h00}}

// ****************************************
// key sequence and source codes
// ****************************************
`define PSM_KEY_FIRST 8'h55
`define PSM_KEY_SECOND 8'hAA
`define PSM_OUT_LAST_RSVD 5'h01
`define PSM_OVR_MASK 32'h0D3F_0F00

`endif

// *** include/psm_pkg.sv ***
// psm_pkg.sv: types shared by the pin select matrix.
// assumes psm_params.svh supplies the numeric constants.
package psm_pkg;

  // progress through the two-key unlock sequence
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_GOT_FIRST,
    KEY_ARMED
  } psm_key_t;

  typedef logic [4:0] psm_sel_t;

endpackage : psm_pkg

// *** rtl/psm_matrix.sv ***
// psm_matrix.sv: pin select matrix routing pins to peripheral inputs and sources to pins.
// assumes sys_rst is power-on/brown-out reset, other_rst a one-cycle pulse for other resets,
// and that peripheral sources and latches are logic on the same clock.
//
// Behaviour
// - input codes 10000-10111 route port C pins 0-7
// - input codes 01100-01111 route port B pins 4-7
// - input codes 00000-00101 route port A pins 0-5
// - input selections reset to per-peripheral defaults on power-on only
// - bits 7-5 of every selection register ignore writes and read zero
// - output selections clear on power-on, unchanged on other resets
// - output codes 11100-11111: timer zero, numeric oscillator, reference clock, modulator
// - output codes 11000-11011: serial port one clock/data, port two clock/data
// - output codes 10110 and 10111: comparator one and two
// - output codes 10100 and 10101: async unit transmit/clock and sync data
// - output codes 10000-10011: waveform generator two outputs A-D
// - output codes 01000-01011: waveform generator one outputs A-D
// - output codes 01100-01111: capture/compare units one to four
// - output codes 00100-00111: logic cells one to four
// - output codes 00010, 00011: pulse modulators five, six; 00000, 00001 reserved
// - marked serial and waveform sources override pin direction when they need
// - lock flag bit 0 set blocks all selection writes
// - lock flag is written only right after keys 0x55 then 0xAA
// - one-shot option allows one clear and one set per reset
// - power-on restores defaults and clears lock; other resets keep selections
// - all selection registers readable at any time
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "psm_params.svh"

module psm_matrix
  import psm_pkg::*;
#(
  parameter int NUM_IN = `PSM_NUM_IN,
  parameter int NUM_OUT = `PSM_NUM_OUT,
  parameter logic [`PSM_NUM_IN*`PSM_SEL_W-1:0] IN_RESET = `PSM_IN_RST
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic other_rst,
  input wire logic one_shot_lock_option,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [5:0] port_a_in,
  input wire logic [3:0] port_b_in,
  input wire logic [7:0] port_c_in,
  output logic [NUM_IN-1:0] peripheral_input_select,
  input wire logic [31:0] periph_src,
  input wire logic [31:0] periph_ovr_req,
  input wire logic [31:0] periph_ovr_drive,
  input wire logic [NUM_OUT-1:0] port_latch,
  input wire logic [NUM_OUT-1:0] pin_direction_control,
  output logic [NUM_OUT-1:0] pin_out,
  output logic [NUM_OUT-1:0] pin_out_oe_n,
  output logic selection_lock_flag
);

  // ****************************************
  // declarations
  // ****************************************
  localparam logic [31:0] OVR_MASK = `PSM_OVR_MASK;

  psm_sel_t in_sel [NUM_IN];
  psm_sel_t out_sel [NUM_OUT];
  psm_sel_t next_in_sel [NUM_IN];
  psm_sel_t next_out_sel [NUM_OUT];
  psm_key_t key_state;
  logic cleared_once;
  logic set_once;
  logic [5:0] a_meta;
  logic [5:0] a_sync;
  logic [3:0] b_meta;
  logic [3:0] b_sync;
  logic [7:0] c_meta;
  logic [7:0] c_sync;
  logic [17:0] pin_sync;
  logic [7:0] read_value;
  logic opt_meta;
  logic opt_sync;
  logic [31:0] in_vector;
  logic [7:0] in_off;
  logic [7:0] out_off;
  logic in_hit;
  logic out_hit;
  logic lock_hit;
  logic sel_wr_ok;
  logic lock_wr_ok;
  logic next_lock;

  // ****************************************
  // pin and option synchronisers
  // ****************************************
  // one pair of flops per pin, grouped by port; each pin is a separate asynchronous level
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      a_meta <= '0;
      a_sync <= '0;
    end else begin
      a_meta <= port_a_in;
      a_sync <= a_meta;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      b_meta <= '0;
      b_sync <= '0;
    end else begin
      b_meta <= port_b_in;
      b_sync <= b_meta;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      c_meta <= '0;
      c_sync <= '0;
    end else begin
      c_meta <= port_c_in;
      c_sync <= c_meta;
    end
  end

  assign pin_sync = {c_sync, b_sync, a_sync};

  // option is a configuration level from outside the clock domain
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      opt_meta <= 1'b0;
      opt_sync <= 1'b0;
    end else begin
      opt_meta <= one_shot_lock_option;
      opt_sync <= opt_meta;
    end
  end

  // ****************************************
  // address decode
  // ****************************************
  assign in_off = reg_addr - `PSM_IN_BASE;
  assign out_off = reg_addr - `PSM_OUT_BASE;
  assign in_hit = (reg_addr >= `PSM_IN_BASE) && (in_off < 8'(NUM_IN));
  assign out_hit = (reg_addr >= `PSM_OUT_BASE) && (out_off < 8'(NUM_OUT));
  assign lock_hit = (reg_addr == `PSM_LOCK_ADDR);
  assign sel_wr_ok = reg_write && !selection_lock_flag;

  // ****************************************
  // next selection values
  // ****************************************
  // routing muxes are fed from next_ values so the change lands on the same edge as the write
  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      next_in_sel[i] = in_sel[i];
      if (sel_wr_ok && in_hit && in_off == 8'(i)) begin
        next_in_sel[i] = reg_wdata[`PSM_SEL_W-1:0];
      end
    end
    for (int j = 0; j < NUM_OUT; j++) begin
      next_out_sel[j] = out_sel[j];
      if (sel_wr_ok && out_hit && out_off == 8'(j)) begin
        next_out_sel[j] = reg_wdata[`PSM_SEL_W-1:0];
      end
    end
  end

  // ****************************************
  // selection registers
  // ****************************************
  // only sys_rst reloads them; other_rst deliberately leaves routing alone
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_IN; i++) begin
        in_sel[i] <= IN_RESET[i*`PSM_SEL_W +: `PSM_SEL_W];
      end
    end else begin
      for (int i = 0; i < NUM_IN; i++) begin
        in_sel[i] <= next_in_sel[i];
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int j = 0; j < NUM_OUT; j++) begin
        out_sel[j] <= `PSM_OUT_RST;
      end
    end else begin
      for (int j = 0; j < NUM_OUT; j++) begin
        out_sel[j] <= next_out_sel[j];
      end
    end
  end

  // ****************************************
  // unlock key sequence
  // ****************************************
  // any other write in between, except a repeated 0x55 to the lock address, breaks the sequence, so keys must be back to back
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      key_state <= KEY_IDLE;
    end else if (other_rst) begin
      key_state <= KEY_IDLE;
    end else if (reg_write) begin
      case (key_state)
        KEY_IDLE: begin
          key_state <= (lock_hit && reg_wdata == `PSM_KEY_FIRST) ? KEY_GOT_FIRST : KEY_IDLE;
        end
        KEY_GOT_FIRST: begin
          if (lock_hit && reg_wdata == `PSM_KEY_SECOND) begin
            key_state <= KEY_ARMED;
          end else if (lock_hit && reg_wdata == `PSM_KEY_FIRST) begin
            key_state <= KEY_GOT_FIRST;
          end else begin
            key_state <= KEY_IDLE;
          end
        end
        KEY_ARMED: begin
          key_state <= KEY_IDLE;
        end
        default: begin
          key_state <= KEY_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // lock flag
  // ****************************************
  assign next_lock = reg_wdata[`PSM_LOCK_BIT];

  always_comb begin
    lock_wr_ok = reg_write && lock_hit && key_state == KEY_ARMED;
    if (opt_sync) begin
      if (next_lock && set_once) begin
        lock_wr_ok = 1'b0;
      end
      if (!next_lock && cleared_once) begin
        lock_wr_ok = 1'b0;
      end
    end
  end

  // every reset clears the flag and re-arms the one-shot allowance
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      selection_lock_flag <= 1'b0;
      cleared_once <= 1'b0;
      set_once <= 1'b0;
    end else if (other_rst) begin
      selection_lock_flag <= 1'b0;
      cleared_once <= 1'b0;
      set_once <= 1'b0;
    end else if (lock_wr_ok) begin
      selection_lock_flag <= next_lock;
      if (next_lock) begin
        set_once <= 1'b1;
      end else begin
        cleared_once <= 1'b1;
      end
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // reads are never gated by the lock; unmapped addresses read zero
  always_comb begin
    read_value = 8'h00;
    if (lock_hit) begin
      read_value = {7'h00, selection_lock_flag};
    end else if (in_hit) begin
      read_value = {3'h0, in_sel[in_off[4:0]]};
    end else if (out_hit) begin
      read_value = {3'h0, out_sel[out_off[3:0]]};
    end
  end

  // data stands one cycle only, zero otherwise
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= read_value;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************
  // input routing
  // ****************************************
  // reserved codes index zero bits of this vector
  always_comb begin
    in_vector = 32'h0000_0000;
    in_vector[5:0] = pin_sync[5:0];
    in_vector[15:12] = pin_sync[9:6];
    in_vector[23:16] = pin_sync[17:10];
  end

  // registered so a selection change never glitches a peripheral input
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      peripheral_input_select <= '0;
    end else begin
      for (int i = 0; i < NUM_IN; i++) begin
        peripheral_input_select[i] <= in_vector[next_in_sel[i]];
      end
    end
  end

  // ****************************************
  // output routing and direction
  // ****************************************
  // periph_src is indexed by source code, so codes above 00001 map one to one onto sources; 00000 and 00001 both take port_latch
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin_out <= '0;
      pin_out_oe_n <= '1;
    end else begin
      for (int j = 0; j < NUM_OUT; j++) begin
        if (next_out_sel[j] <= `PSM_OUT_LAST_RSVD) begin
          pin_out[j] <= port_latch[j];
        end else begin
          pin_out[j] <= periph_src[next_out_sel[j]];
        end
        if (OVR_MASK[next_out_sel[j]] && periph_ovr_req[next_out_sel[j]]) begin
          pin_out_oe_n[j] <= !periph_ovr_drive[next_out_sel[j]];
        end else begin
          pin_out_oe_n[j] <= pin_direction_control[j];
        end
      end
    end
  end

endmodule : psm_matrix

// *** sim/psm_periph_model.sv ***
// psm_periph_model.sv: stand-in for the peripherals and port pins around the matrix.
// assumes its controls change just after a rising edge, so every output does too.
`timescale 1ns/1ps
module psm_periph_model (
  input wire logic flip,
  input wire logic ovr_on,
  input wire logic ovr_drv,
  output logic [31:0] periph_src,
  output logic [31:0] periph_ovr_req,
  output logic [31:0] periph_ovr_drive,
  output logic [5:0] port_a_in,
  output logic [3:0] port_b_in,
  output logic [7:0] port_c_in,
  output logic [15:0] port_latch,
  output logic [15:0] pin_direction_control
);
  // flip inverts every line except override request and drive, so each source is seen at both levels
  assign periph_src = {32{flip}} ^ 32'hC3A5_5A3C;
  assign port_a_in = {6{flip}} ^ 6'h2D;
  assign port_b_in = {4{flip}} ^ 4'h6;
  assign port_c_in = {8{flip}} ^ 8'hB4;
  assign port_latch = {16{flip}} ^ 16'h5AA5;
  assign pin_direction_control = {16{flip}} ^ 16'hFFFF;
  // with ovr_on every source asks for the pin; only the marked ones may get it
  assign periph_ovr_req = {32{ovr_on}};
  assign periph_ovr_drive = {32{ovr_drv}};
endmodule : psm_periph_model

// *** sim/psm_matrix_assertions.sv ***
// psm_matrix_assertions.sv: port-level checks of the pin select matrix.
// assumes it is bound onto psm_matrix; routing is watched on pin 0 only.
`timescale 1ns/1ps
`include "psm_params.svh"
module psm_matrix_assertions #(
  parameter int NUM_IN = 28,
  parameter int NUM_OUT = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic other_rst,
  input wire logic one_shot_lock_option,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [31:0] periph_src,
  input wire logic [31:0] periph_ovr_req,
  input wire logic [31:0] periph_ovr_drive,
  input wire logic [NUM_OUT-1:0] port_latch,
  input wire logic [NUM_OUT-1:0] pin_direction_control,
  input wire logic [NUM_OUT-1:0] pin_out,
  input wire logic [NUM_OUT-1:0] pin_out_oe_n,
  input wire logic selection_lock_flag
);
  logic [4:0] sel0;
  logic [31:0] src_q, req_q, drv_q;
  logic lat_q, dir_q;
  wire lk_wr = reg_write && reg_addr == `PSM_LOCK_ADDR;
  wire wr_55 = lk_wr && reg_wdata == `PSM_KEY_FIRST;
  wire wr_aa = lk_wr && reg_wdata == `PSM_KEY_SECOND;
  wire [31:0] ovr_mask = `PSM_OVR_MASK;
  // mirror of pin 0 selection; reset values match the outputs so the first edge is clean
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      {src_q, req_q, drv_q, lat_q, dir_q} <= {97'h0, 1'b1};
      sel0 <= 5'h00;
    end else begin
      {src_q, req_q, drv_q} <= {periph_src, periph_ovr_req, periph_ovr_drive};
      {lat_q, dir_q} <= {port_latch[0], pin_direction_control[0]};
      if (reg_write && reg_addr == `PSM_OUT_BASE && !selection_lock_flag) begin
        sel0 <= reg_wdata[4:0];
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence key_pair;
    wr_55 ##1 wr_aa;
  endsequence
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  upper_zero_a: assert property (reg_read |=> reg_rdata[7:5] == 3'h0)
    else $error("upper read bits not zero");
  lock_read_a: assert property (reg_read && lk_wr == 1'b0 && reg_addr == `PSM_LOCK_ADDR
    |=> reg_rdata == {7'h00, $past(selection_lock_flag)}) else $error("lock read mismatch");
  lock_keyed_a: assert property (key_pair ##1 (lk_wr && !other_rst && !one_shot_lock_option)
    |=> selection_lock_flag == $past(reg_wdata[0])) else $error("keyed lock write lost");
  flag_hold_a: assert property (!other_rst && !(lk_wr && $past(wr_aa) && $past(wr_55, 2))
    |=> $stable(selection_lock_flag)) else $error("lock flag moved without keys");
  pin_source_a: assert property (sel0 > 5'h01 |-> pin_out[0] == src_q[sel0])
    else $error("pin 0 not driven by selected source");
  pin_latch_a: assert property (sel0 < 5'h02 |-> pin_out[0] == lat_q)
    else $error("reserved code not driving port latch");
  pin_dir_a: assert property (pin_out_oe_n[0] == ((ovr_mask[sel0] && req_q[sel0]) ? !drv_q[sel0] : dir_q))
    else $error("pin 0 direction wrong");
  other_clear_a: assert property (other_rst |=> !selection_lock_flag)
    else $error("other reset left lock set");
  reset_state_a: assert property (disable iff (1'b0) sys_rst && $past(sys_rst)
    |-> !selection_lock_flag && reg_rdata == 8'h00 && pin_out_oe_n == '1) else $error("bad reset state");
endmodule : psm_matrix_assertions

// *** sim/testbench.sv ***
// testbench.sv: self-checking bench for the pin select matrix and its peripheral model.
// assumes the design, the checker and the peripheral model are compiled before it.
`timescale 1ns/1ps
`include "psm_params.svh"
module testbench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic other_rst = 1'b0;
  logic one_shot_lock_option = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic flip = 1'b0;
  logic ovr_on = 1'b0;
  logic ovr_drv = 1'b0;
  logic [7:0] reg_rdata;
  logic [5:0] port_a_in;
  logic [3:0] port_b_in;
  logic [7:0] port_c_in;
  logic [27:0] peripheral_input_select;
  logic [31:0] periph_src, periph_ovr_req, periph_ovr_drive;
  logic [15:0] port_latch, pin_direction_control, pin_out, pin_out_oe_n;
  logic selection_lock_flag;
  int failures = 0;
  int samples_checked = 0;
  // address, write data, read back: boundaries, masked bits, unmapped places
  logic [23:0] rows [7] = '{24'h21FC1C, 24'h01F717, 24'h1CE303, 24'h2FA505, 24'h1D1200, 24'h000100, 24'h300F00};
  always #12.5 clock = ~clock;
  psm_matrix u_psm_matrix (.clock(clock), .sys_rst(sys_rst), .other_rst(other_rst),
    .one_shot_lock_option(one_shot_lock_option), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .port_a_in(port_a_in),
    .port_b_in(port_b_in), .port_c_in(port_c_in), .peripheral_input_select(peripheral_input_select),
    .periph_src(periph_src), .periph_ovr_req(periph_ovr_req), .periph_ovr_drive(periph_ovr_drive),
    .port_latch(port_latch), .pin_direction_control(pin_direction_control), .pin_out(pin_out),
    .pin_out_oe_n(pin_out_oe_n), .selection_lock_flag(selection_lock_flag));
  psm_periph_model u_psm_periph_model (.flip(flip), .ovr_on(ovr_on), .ovr_drv(ovr_drv), .periph_src(periph_src),
    .periph_ovr_req(periph_ovr_req), .periph_ovr_drive(periph_ovr_drive), .port_a_in(port_a_in), .port_b_in(port_b_in),
    .port_c_in(port_c_in), .port_latch(port_latch), .pin_direction_control(pin_direction_control));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clock);
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      other_rst <= 1'b0;
    end
    #1;
  endtask : cyc
  // strobe stays up so writes can follow each other with no gap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    {reg_addr, reg_wdata, reg_write, reg_read} <= {a, d, 2'b10};
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    {reg_addr, reg_write, reg_read} <= {a, 2'b01};
    cyc(1);
    check(reg_rdata, exp);
  endtask : rd
  task automatic keys(input logic v);
    wr(`PSM_LOCK_ADDR, `PSM_KEY_FIRST);
    wr(`PSM_LOCK_ADDR, `PSM_KEY_SECOND);
    wr(`PSM_LOCK_ADDR, {7'h00, v});
    cyc(2);
  endtask : keys
  function automatic logic exp_in(input int c);
    if (c < 6) return port_a_in[c];
    if (c >= 12 && c < 16) return port_b_in[c - 12];
    if (c >= 16 && c < 24) return port_c_in[c - 16];
    return 1'b0;
  endfunction : exp_in
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    rd(`PSM_OUT_BASE, 8'h00);
    rd(`PSM_LOCK_ADDR, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    $display("register rows done");
    // input codes 6, 7 and 24-31 are never stored, so those slots take pin A5 instead; reserved 8-11 are stored
    for (int c = 0; c < 32; c++) begin
      wr(`PSM_OUT_BASE, 8'(c));
      {flip, ovr_on, ovr_drv} <= {c[1], !(c[1] && c[0]), c[0]};
      wr(`PSM_IN_BASE, (c inside {6, 7, [24:31]}) ? 8'h05 : 8'(c));
      cyc(5);
      check(pin_out[0], (c > 1) ? periph_src[c] : port_latch[0]);
      check(pin_out_oe_n[0], ((c inside {[8:11], [16:21], 24, 26, 27}) && !(c[1] && c[0])) ?
        !c[0] : pin_direction_control[0]);
      check(peripheral_input_select[0], exp_in((c inside {6, 7, [24:31]}) ? 5 : c));
    end
    $display("routing done");
    keys(1'b1);
    check(selection_lock_flag, 1'b1);
    wr(`PSM_OUT_BASE, 8'h07);
    rd(`PSM_OUT_BASE, 8'h1F);
    wr(`PSM_LOCK_ADDR, 8'h00);
    cyc(1);
    check(selection_lock_flag, 1'b1);
    keys(1'b0);
    wr(`PSM_OUT_BASE, 8'h05);
    wr(`PSM_LOCK_ADDR, `PSM_KEY_FIRST);
    wr(8'h21, 8'h00);
    wr(`PSM_LOCK_ADDR, `PSM_KEY_SECOND);
    wr(`PSM_LOCK_ADDR, 8'h01);
    cyc(2);
    check(selection_lock_flag, 1'b0);
    $display("lock keys done");
    keys(1'b1);
    @(posedge clock);
    other_rst <= 1'b1;
    cyc(1);
    check(selection_lock_flag, 1'b0);
    rd(`PSM_OUT_BASE, 8'h05);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd(`PSM_OUT_BASE, 8'h00);
    rd(`PSM_IN_BASE, 8'h00);
    $display("resets done");
    @(posedge clock);
    one_shot_lock_option <= 1'b1;
    cyc(4);
    keys(1'b1);
    keys(1'b0);
    check(selection_lock_flag, 1'b0);
    keys(1'b1);
    check(selection_lock_flag, 1'b0);
    $display("one-shot lock done");
    wrap_up();
  end
endmodule : testbench
bind psm_matrix psm_matrix_assertions #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) u_psm_matrix_assertions (
  .clock(clock), .sys_rst(sys_rst), .other_rst(other_rst), .one_shot_lock_option(one_shot_lock_option),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .periph_src(periph_src), .periph_ovr_req(periph_ovr_req), .periph_ovr_drive(periph_ovr_drive),
  .port_latch(port_latch), .pin_direction_control(pin_direction_control), .pin_out(pin_out),
  .pin_out_oe_n(pin_out_oe_n), .selection_lock_flag(selection_lock_flag));
